//--- shared/ctnx_pkg.sv
package ctnx_pkg;
  localparam int          CTNX_OP_W      = 10;
  localparam int          CTNX_ACC_W     = 4;
  localparam int          CTNX_PC_W      = 11;
  localparam logic [9:0]  CTNX_OP_CARRY_TEST = 10'h353;
  localparam logic [9:0]  CTNX_OP_NOP    = 10'h000;
  localparam logic [3:0]  CTNX_ACC_ALL1  = 4'hf;
  localparam logic [3:0]  CTNX_ACC_RST   = 4'h0;
  localparam logic        CTNX_CARRY_RST = 1'b0;
  localparam logic [10:0] CTNX_PC_RST    = 11'h000;
  localparam logic [10:0] CTNX_PC_STEP   = 11'h001;

  typedef enum logic [1:0] {
    CTNX_IDLE,
    CTNX_EXEC
  } ctnx_state_t;
endpackage

//--- rtl/ctnx_run_mask.sv
`timescale 1ns/1ps
module ctnx_run_mask #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] acc_in,
  output logic      [W-1:0] acc_out,
  output logic              all_ones
);
  // Bit i survives only while every bit below it is one
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign acc_out[i] = &acc_in[i:0];
    end
  endgenerate

  assign all_ones = &acc_in;
endmodule

//--- rtl/ctnx_exec.sv
`timescale 1ns/1ps
module ctnx_exec #(
  parameter int ACC_W = ctnx_pkg::CTNX_ACC_W,
  parameter int PC_W  = ctnx_pkg::CTNX_PC_W
) (
  // Clock and synchronous reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,

  // Instruction offered by the fetch side this cycle
  input  wire logic                          instr_valid,
  input  wire logic [ctnx_pkg::CTNX_OP_W-1:0] instr_code,

  // Core writes into the shared registers
  input  wire logic                          acc_load,
  input  wire logic [ACC_W-1:0]              acc_load_data,
  input  wire logic                          carry_load,
  input  wire logic                          carry_load_data,
  input  wire logic                          pc_load,
  input  wire logic [PC_W-1:0]               pc_load_data,

  // Registered state seen by the rest of the core
  output logic      [ACC_W-1:0]              acc,
  output logic                               carry_flag,
  output logic      [PC_W-1:0]               program_counter,

  // One-cycle status pulses
  output logic                               instr_done,
  output logic                               instr_unknown
);

  // Opcode width follows the package so decode tracks the code table
  localparam int OP_W = ctnx_pkg::CTNX_OP_W;

  // What the decoder made of the code offered this cycle
  typedef enum logic [1:0] {
    CTNX_KIND_NONE,
    CTNX_KIND_CARRY_TEST,
    CTNX_KIND_NOP,
    CTNX_KIND_OTHER
  } ctnx_kind_t;

  // All state of the block lives in one packed struct
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             carry;
    logic [PC_W-1:0]  pc;
    logic             done;
    logic             unknown;
  } ctnx_state_reg_t;

  ctnx_state_reg_t  st_reg;
  ctnx_state_reg_t  st_next;
  ctnx_state_reg_t  st_rst;

  logic [ACC_W-1:0] masked;
  logic             all_ones;
  logic [ACC_W-1:0] test_acc;
  logic             test_carry;

  logic [OP_W-1:0]  test_bit_ok;
  logic [OP_W-1:0]  nop_bit_ok;
  logic             is_test;
  logic             is_nop;
  logic             op_busy;
  ctnx_kind_t       kind;

  logic             acc_take;
  logic             carry_take;
  logic             pc_take;

  logic [PC_W-1:0]  pc_step;
  logic [PC_W-1:0]  pc_inc;

  // Lowest run of ones and the all-ones test share one mask
  ctnx_run_mask #(
    .W (ACC_W)
  ) u_mask (
    .acc_in   (st_reg.acc),
    .acc_out  (masked),
    .all_ones (all_ones)
  );

  // Results of the carry test, formed beside the state they replace
  assign test_acc   = masked;
  assign test_carry = all_ones;

  // One compare per opcode bit; a code must match in full
  genvar b;

  generate
    for (b = 0; b < OP_W; b++) begin : g_code_bit
      assign test_bit_ok[b] =
        instr_code[b] == ctnx_pkg::CTNX_OP_CARRY_TEST[b];
      assign nop_bit_ok[b] =
        instr_code[b] == ctnx_pkg::CTNX_OP_NOP[b];
    end
  endgenerate

  // Valid qualifies both decodes so idle cycles do nothing
  assign is_test =
    instr_valid && (&test_bit_ok);
  assign is_nop =
    instr_valid && (&nop_bit_ok);
  assign op_busy =
    is_test || is_nop;

  assign kind = !instr_valid ? CTNX_KIND_NONE
              : is_test      ? CTNX_KIND_CARRY_TEST
              : is_nop       ? CTNX_KIND_NOP
              :                CTNX_KIND_OTHER;

  // Core writes lose to a local op so its result is never torn
  assign acc_take =
    acc_load && !op_busy;
  assign carry_take =
    carry_load && !op_busy;
  assign pc_take =
    pc_load && !op_busy;

  // Counter wraps at its width like the rest of the core
  assign pc_step = PC_W'(ctnx_pkg::CTNX_PC_STEP);
  assign pc_inc  = PC_W'(st_reg.pc + pc_step);

  // Reset image of the state, built from the package constants
  assign st_rst = '{
    acc:     ACC_W'(ctnx_pkg::CTNX_ACC_RST),
    carry:   ctnx_pkg::CTNX_CARRY_RST,
    pc:      PC_W'(ctnx_pkg::CTNX_PC_RST),
    done:    1'b0,
    unknown: 1'b0
  };

  always_comb begin
    // Pulses last one cycle unless an op below raises them
    st_next         = st_reg;
    st_next.done    = 1'b0;
    st_next.unknown = 1'b0;

    unique case (kind)
      CTNX_KIND_CARRY_TEST: begin
        st_next.carry = test_carry;

        st_next.acc   = test_acc;

        st_next.pc    = pc_inc;

        st_next.done  = 1'b1;
      end

      CTNX_KIND_NOP: begin
        // Loads are dropped too: nothing but the counter moves
        st_next.acc   = st_reg.acc;

        st_next.carry = st_reg.carry;

        st_next.pc    = pc_inc;

        st_next.done  = 1'b1;
      end

      CTNX_KIND_OTHER: begin
        // Another unit runs this code; only the pulse is ours
        st_next.unknown = 1'b1;

        if (acc_take) begin
          st_next.acc = acc_load_data;
        end

        if (carry_take) begin
          st_next.carry = carry_load_data;
        end

        if (pc_take) begin
          st_next.pc = pc_load_data;
        end
      end

      CTNX_KIND_NONE: begin
        // Nothing offered: only core writes can change the state
        if (acc_take) begin
          st_next.acc = acc_load_data;
        end

        if (carry_take) begin
          st_next.carry = carry_load_data;
        end

        if (pc_take) begin
          st_next.pc = pc_load_data;
        end
      end
    endcase
  end

  // Synchronous reset: the whole struct returns to its reset image
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= st_rst;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output is a flip-flop of the state struct
  assign acc             = st_reg.acc;

  assign carry_flag      = st_reg.carry;

  assign program_counter = st_reg.pc;

  assign instr_done      = st_reg.done;

  assign instr_unknown   = st_reg.unknown;
endmodule

//--- dv/ctnx_exec_monitor.sv
`timescale 1ns/1ps
module ctnx_exec_monitor (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        instr_valid,
  input wire logic [9:0]  instr_code,
  input wire logic [3:0]  acc,
  input wire logic        carry_flag,
  input wire logic [10:0] program_counter,
  input wire logic        instr_done,
  input wire logic        instr_unknown
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire       t = instr_valid && instr_code == ctnx_pkg::CTNX_OP_CARRY_TEST;
  wire       n = instr_valid && instr_code == ctnx_pkg::CTNX_OP_NOP;
  wire       u = instr_valid && !t && !n;
  wire [3:0] m = {&acc, &acc[2:0], &acc[1:0], acc[0]};
  wire [10:0] p = program_counter + 11'h1;
  chk_test_done: assert property (t |=> instr_done)
    else $error("no done");
  chk_carry_set: assert property (t |=> carry_flag == &$past(acc))
    else $error("bad carry");
  chk_acc_run: assert property (t |=> acc == $past(m))
    else $error("bad acc");
  chk_nop_hold: assert property (n |=> instr_done && acc == $past(acc)
    && carry_flag == $past(carry_flag) && program_counter == $past(p))
    else $error("nop changed state");
  chk_test_pc: assert property (t |=> program_counter == $past(p))
    else $error("bad pc");
  chk_unknown_pulse: assert property (u |=> instr_unknown
    && !instr_done)
    else $error("no unknown pulse");
endmodule

//--- dv/ctnx_exec_tb.sv
`timescale 1ns/1ps
module ctnx_exec_tb;
  logic        sys_clk = 0, sys_rst = 1, instr_valid = 0, acc_load = 0;
  logic        carry_load = 0, carry_load_data = 0, pc_load = 0;
  logic        carry_flag, instr_done, instr_unknown;
  logic [9:0]  instr_code = 0;
  logic [3:0]  acc_load_data = 0, acc;
  logic [10:0] pc_load_data = 0, program_counter;
  int          errors = 0, n_tests = 0;
  logic [8:0]  rows [5] = '{9'h1c0, 9'h0a2, 9'h166, 9'h0ee, 9'h1ff};
  always #4 sys_clk = ~sys_clk;
  ctnx_exec ctnx_exec_inst (.sys_clk, .sys_rst, .instr_valid, .instr_code,
    .acc_load, .acc_load_data, .carry_load, .carry_load_data, .pc_load,
    .pc_load_data, .acc, .carry_flag, .program_counter, .instr_done,
    .instr_unknown);
  task cmp(input string name, input logic [10:0] e, s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", name, e, s);
    end
  endtask
  // Loads stay on during the op: they must lose to it
  task run(input logic [9:0] c, input logic [3:0] a, ea, input logic lc, ec);
    @(posedge sys_clk);
    {acc_load, carry_load, pc_load} <= 3'h7;
    acc_load_data <= a;
    carry_load_data <= lc;
    pc_load_data <= 11'h7ff;
    @(posedge sys_clk);
    {instr_valid, instr_code, acc_load_data} <= {1'b1, c, ~a};
    pc_load_data <= 11'h123;
    @(posedge sys_clk);
    {instr_valid, acc_load, carry_load, pc_load} <= 4'h0;
    #1;
    cmp("acc", ea, acc);
    cmp("carry_flag", ec, carry_flag);
    cmp("program_counter", 11'h000, program_counter);
    cmp("instr_done", 1'b1, instr_done);
    cmp("instr_unknown", 1'b0, instr_unknown);
    $display("op %h ended", c);
  endtask
  task end_of_test;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    foreach (rows[i]) run(ctnx_pkg::CTNX_OP_CARRY_TEST, rows[i][8:5],
      rows[i][4:1], ~rows[i][0], rows[i][0]);
    run(ctnx_pkg::CTNX_OP_NOP, 4'h5, 4'h5, 1'b1, 1'b1);
    // Unknown code: the load goes through and only the unknown pulse rises
    @(posedge sys_clk);
    {instr_valid, instr_code} <= {1'b1, 10'h155};
    {acc_load, acc_load_data} <= {1'b1, 4'h9};
    @(posedge sys_clk);
    {instr_valid, acc_load} <= 2'h0;
    #1;
    cmp("instr_unknown", 11'h001, instr_unknown);
    cmp("instr_done", 11'h000, instr_done);
    cmp("acc", 11'h009, acc);
    $display("unknown code ended");
    // Reset in mid-run, then after release a carry test, offered behind the run task's load cycle
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp("carry_flag", 11'h000, carry_flag);
    cmp("acc", 11'h000, acc);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    $display("reset ended");
    run(ctnx_pkg::CTNX_OP_CARRY_TEST, 4'h3, 4'h3, 1'b1, 1'b0);
    end_of_test;
  end
  initial begin
    #2000 errors++;
    end_of_test;
  end
endmodule
bind ctnx_exec ctnx_exec_monitor ctnx_exec_monitor_inst (.sys_clk, .sys_rst,
  .instr_valid, .instr_code, .acc, .carry_flag, .program_counter, .instr_done,
  .instr_unknown);
